// *** rtl/bbfs_ctrl.sv ***
// bus brake chopper and fault stop supervisor
`timescale 1ns/1ns
module bbfs_ctrl #(
    // bus check period in clocks; a parameter so a bench can shorten the wait
    parameter int CHECK_CYCLES_P = bbfs_pkg::CHECK_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // settings
    input wire logic supply_class_400,
    input wire logic enable_loss_response,
    input wire logic fault_action_select,
    input wire logic phase_loss_response,
    input wire logic holding_brake_enable,
    input wire logic [11:0] bus_voltage_minimum,
    // measurements and pins
    input wire logic [11:0] bus_voltage,
    input wire logic brake_power_over,
    input wire logic phase_missing_pin,
    input wire logic enable_pin,
    input wire logic stop_cat0_pin,
    input wire logic stop_cat1_pin,
    input wire logic standstill,
    input wire logic fault_clear,
    // outputs
    output logic chopper_on,
    output logic brake_power_exceeded,
    output logic power_stage_on,
    output logic ramp_active,
    output logic special_off_seq,
    output logic current_limit,
    output logic ready_to_operate_contact,
    output logic phase_missing_warning,
    output logic mains_not_ready_error,
    output logic [3:0] error_code_query,
    output logic [2:0] stop_status
);
    // ********************************************
    // input synchronisers
    // ********************************************
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic phase_missing_s;
    logic enable_s;
    logic cat0_s;
    logic cat1_s;
    logic standstill_s;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
        end else begin
            sync1_q <= {phase_missing_pin, enable_pin, stop_cat0_pin, stop_cat1_pin, standstill};
            sync2_q <= sync1_q;
        end
    end
    assign phase_missing_s = sync2_q[4];
    assign enable_s = sync2_q[3];
    assign cat0_s = sync2_q[2];
    assign cat1_s = sync2_q[1];
    assign standstill_s = sync2_q[0];

    // ********************************************
    // chopper hysteresis
    // ********************************************
    function automatic logic [11:0] thr_sel(input logic cls, input logic upper);
        if (cls)
            thr_sel = upper ? bbfs_pkg::CHOP_ON_400 : bbfs_pkg::CHOP_OFF_400;
        else
            thr_sel = upper ? bbfs_pkg::CHOP_ON_230 : bbfs_pkg::CHOP_OFF_230;
    endfunction

    logic [11:0] thr_on;
    logic [11:0] thr_off;
    logic chop_q;
    logic bpe_q;
    assign thr_on = thr_sel(supply_class_400, 1'b1);
    assign thr_off = thr_sel(supply_class_400, 1'b0);

    // brake power latch holds the chopper off until faults are cleared
    always_ff @(posedge clk_sys) begin
        if (rst)
            bpe_q <= 1'b0;
        else if (brake_power_over)
            bpe_q <= 1'b1;
        else if (fault_clear)
            bpe_q <= 1'b0;
    end

    always_ff @(posedge clk_sys) begin
        if (rst)
            chop_q <= 1'b0;
        else if (bpe_q || brake_power_over)
            chop_q <= 1'b0;
        else if (bus_voltage >= thr_on)
            chop_q <= 1'b1;
        else if (bus_voltage <= thr_off)
            chop_q <= 1'b0;
    end
    assign chopper_on = chop_q;
    assign brake_power_exceeded = bpe_q;
    a_bpe_sticky: assert property (@(posedge clk_sys) disable iff (rst)
        (bpe_q && !fault_clear) |=> bpe_q)
        else $error("brake power flag dropped");
    a_bpe_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (fault_clear && !brake_power_over) |=> !bpe_q)
        else $error("brake power flag not cleared");

    // ********************************************
    // periodic bus check
    // ********************************************
    logic [27:0] chk_cnt_q;
    logic chk_tick;
    assign chk_tick = (chk_cnt_q == 28'(CHECK_CYCLES_P - 1));
    always_ff @(posedge clk_sys) begin
        if (rst || chk_tick)
            chk_cnt_q <= 28'h0000000;
        else
            chk_cnt_q <= chk_cnt_q + 28'h0000001;
    end

    // ********************************************
    // fault capture; first error wins the code
    // ********************************************
    logic ov_set;
    logic uv_set;
    logic ph_err_set;
    logic [3:0] err_q;
    logic fault_q;
    assign ov_set = chk_tick && (bus_voltage >= thr_on) && (bpe_q || brake_power_over);
    assign uv_set = chk_tick && (bus_voltage < bus_voltage_minimum);
    assign ph_err_set = phase_missing_s && phase_loss_response;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            err_q <= bbfs_pkg::ERR_NONE;
            fault_q <= 1'b0;
        end else if (ov_set || uv_set || ph_err_set) begin
            fault_q <= 1'b1;
            if (!fault_q) begin
                if (ov_set)
                    err_q <= bbfs_pkg::ERR_OVERVOLT;
                else if (ph_err_set)
                    err_q <= bbfs_pkg::ERR_INPUT_PHASE;
                else
                    err_q <= bbfs_pkg::ERR_UNDERVOLT;
            end
        end else if (fault_clear) begin
            fault_q <= 1'b0;
            err_q <= bbfs_pkg::ERR_NONE;
        end
    end
    assign error_code_query = err_q;

    // a phase error still present keeps the contact open through a clear; bus causes do so only on a check tick
    a_ov_code: assert property (@(posedge clk_sys) disable iff (rst)
        (ov_set && !fault_q) |=> (error_code_query == bbfs_pkg::ERR_OVERVOLT))
        else $error("overvoltage code not latched");
    a_phase_code: assert property (@(posedge clk_sys) disable iff (rst)
        (ph_err_set && !ov_set && !fault_q)
            |=> (error_code_query == bbfs_pkg::ERR_INPUT_PHASE && !ready_to_operate_contact))
        else $error("input phase error not latched");
    a_uv_code: assert property (@(posedge clk_sys) disable iff (rst)
        (uv_set && !ov_set && !ph_err_set && !fault_q)
            |=> (error_code_query == bbfs_pkg::ERR_UNDERVOLT && !ready_to_operate_contact))
        else $error("undervoltage error not latched");
    a_fault_hold: assert property (@(posedge clk_sys) disable iff (rst)
        (fault_q && !fault_clear) |=> !ready_to_operate_contact)
        else $error("ready contact closed with fault latched");

    // ********************************************
    // phase loss warning path
    // ********************************************
    logic warn_q;
    always_ff @(posedge clk_sys) begin
        if (rst)
            warn_q <= 1'b0;
        else
            warn_q <= phase_missing_s && !phase_loss_response;
    end
    assign phase_missing_warning = warn_q;
    assign mains_not_ready_error = warn_q;
    assign current_limit = warn_q;

    // ********************************************
    // stop sequencer
    // ********************************************
    bbfs_pkg::bbfs_state_e state_q;
    logic [29:0] to_cnt_q;
    logic ramp_done;
    assign ramp_done = standstill_s || (to_cnt_q == 30'(bbfs_pkg::STOP_TIMEOUT_CYCLES - 1));

    always_ff @(posedge clk_sys) begin
        if (rst || state_q != bbfs_pkg::BBFS_RAMP)
            to_cnt_q <= 30'h00000000;
        else
            to_cnt_q <= to_cnt_q + 30'h00000001;
    end

    // fault disables must take effect the same cycle, hence immediate checks
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= bbfs_pkg::BBFS_OFF;
        end else begin
            unique case (state_q)
                bbfs_pkg::BBFS_OFF: begin
                    if (enable_s && !fault_q && !cat0_s && !cat1_s)
                        state_q <= bbfs_pkg::BBFS_RUN;
                end
                bbfs_pkg::BBFS_RUN: begin
                    if (cat0_s || ov_set)
                        state_q <= bbfs_pkg::BBFS_COAST;
                    else if ((ph_err_set || uv_set) && !fault_action_select)
                        state_q <= bbfs_pkg::BBFS_COAST;
                    else if (ph_err_set || uv_set)
                        state_q <= bbfs_pkg::BBFS_RAMP;
                    else if (cat1_s)
                        state_q <= bbfs_pkg::BBFS_RAMP;
                    else if (!enable_s && (enable_loss_response || holding_brake_enable))
                        state_q <= bbfs_pkg::BBFS_RAMP;
                    else if (!enable_s)
                        state_q <= bbfs_pkg::BBFS_COAST;
                end
                bbfs_pkg::BBFS_RAMP: begin
                    if (cat0_s || ov_set)
                        state_q <= bbfs_pkg::BBFS_COAST;
                    else if (ramp_done)
                        state_q <= bbfs_pkg::BBFS_OFF;
                end
                bbfs_pkg::BBFS_COAST: begin
                    if (!enable_s && !cat0_s)
                        state_q <= bbfs_pkg::BBFS_OFF;
                end
                default: state_q <= bbfs_pkg::BBFS_OFF;
            endcase
        end
    end

    logic hb_q;
    always_ff @(posedge clk_sys) begin
        if (rst)
            hb_q <= 1'b0;
        else
            hb_q <= holding_brake_enable && state_q == bbfs_pkg::BBFS_RAMP && !enable_s;
    end
    assign special_off_seq = hb_q;

    assign power_stage_on = (state_q == bbfs_pkg::BBFS_RUN) || (state_q == bbfs_pkg::BBFS_RAMP);
    assign ramp_active = (state_q == bbfs_pkg::BBFS_RAMP);
    assign ready_to_operate_contact = !fault_q;
    assign stop_status = state_q;

    // ********************************************
    // checks
    // ********************************************
    a_chop_on_thr: assert property (@(posedge clk_sys) disable iff (rst)
        (!bpe_q && !brake_power_over && bus_voltage >= thr_on) |=> chop_q)
        else $error("chopper not on at threshold");
    a_chop_off_thr: assert property (@(posedge clk_sys) disable iff (rst)
        (bus_voltage <= thr_off && bus_voltage < thr_on) |=> !chop_q)
        else $error("chopper not off at threshold");
    a_chop_hold: assert property (@(posedge clk_sys) disable iff (rst)
        (!bpe_q && !brake_power_over && bus_voltage > thr_off && bus_voltage < thr_on) |=> $stable(chop_q))
        else $error("chopper changed between thresholds");
    a_thr_class: assert property (@(posedge clk_sys) disable iff (rst)
        supply_class_400 |-> (thr_on == 12'h2d0 && thr_off == 12'h2a8))
        else $error("wrong 400 V thresholds");
    a_thr_low: assert property (@(posedge clk_sys) disable iff (rst)
        !supply_class_400 |-> (thr_on == 12'h190 && thr_off == 12'h17c))
        else $error("wrong 230 V thresholds");
    a_bpe_kill: assert property (@(posedge clk_sys) disable iff (rst)
        brake_power_over |=> (!chop_q && bpe_q))
        else $error("brake power not handled");
    a_ov_rdy: assert property (@(posedge clk_sys) disable iff (rst)
        ov_set |=> (!ready_to_operate_contact && !power_stage_on))
        else $error("overvoltage did not shut down");
    a_ov_coast: assert property (@(posedge clk_sys) disable iff (rst)
        (ov_set && (state_q == bbfs_pkg::BBFS_RUN || state_q == bbfs_pkg::BBFS_RAMP))
            |=> (state_q == bbfs_pkg::BBFS_COAST))
        else $error("overvoltage did not disable the stage");
    a_cat0_prio: assert property (@(posedge clk_sys) disable iff (rst)
        (cat0_s && state_q != bbfs_pkg::BBFS_OFF) |=> !power_stage_on)
        else $error("category 0 not immediate");
    sequence s_phase_err;
        (state_q == bbfs_pkg::BBFS_RUN) && ph_err_set && fault_action_select && !cat0_s && !ov_set;
    endsequence
    a_phase_ramp: assert property (@(posedge clk_sys) disable iff (rst)
        s_phase_err |=> (ramp_active && !ready_to_operate_contact))
        else $error("phase error did not ramp");
    a_warn_out: assert property (@(posedge clk_sys) disable iff (rst)
        (phase_missing_s && !phase_loss_response) |=> (mains_not_ready_error && current_limit))
        else $error("phase warning missing");

    // ********************************************
    // stop sequence checks
    // ********************************************
    a_fa0_coast: assert property (@(posedge clk_sys) disable iff (rst)
        ((state_q == bbfs_pkg::BBFS_RUN) && (ph_err_set || uv_set) && !fault_action_select)
            |=> (state_q == bbfs_pkg::BBFS_COAST))
        else $error("fault with action 0 did not coast");
    a_off_refuse: assert property (@(posedge clk_sys) disable iff (rst)
        ((state_q == bbfs_pkg::BBFS_OFF) && (fault_q || cat0_s || cat1_s)) |=> !power_stage_on)
        else $error("start accepted against a stop or fault");
    a_cat1_ramp: assert property (@(posedge clk_sys) disable iff (rst)
        ((state_q == bbfs_pkg::BBFS_RUN) && cat1_s && !cat0_s && !ov_set && !ph_err_set && !uv_set)
            |=> (ramp_active && power_stage_on))
        else $error("category 1 stop did not ramp");
    a_ramp_end: assert property (@(posedge clk_sys) disable iff (rst)
        ((state_q == bbfs_pkg::BBFS_RAMP) && standstill_s && !cat0_s && !ov_set)
            |=> (state_q == bbfs_pkg::BBFS_OFF))
        else $error("ramp did not end at standstill");
    a_warn_stay: assert property (@(posedge clk_sys) disable iff (rst)
        ((state_q == bbfs_pkg::BBFS_RUN) && phase_missing_s && !phase_loss_response && enable_s && !cat0_s
            && !cat1_s && !ov_set && !uv_set) |=> power_stage_on)
        else $error("phase warning disabled the stage");
    sequence s_hb_release;
        (state_q == bbfs_pkg::BBFS_RUN) && holding_brake_enable && !enable_s && !cat0_s && !cat1_s
            && !ov_set && !ph_err_set && !uv_set;
    endsequence
    sequence s_hb_brake;
        ramp_active ##1 special_off_seq;
    endsequence
    a_hb_brake: assert property (@(posedge clk_sys) disable iff (rst)
        s_hb_release |=> s_hb_brake)
        else $error("holding brake release did not brake");
endmodule // bbfs_ctrl

// *** rtl/bbfs_pkg.sv ***
// constants for the bus brake and fault stop controller
package bbfs_pkg;
    // ********************************************
    // bus voltage thresholds, volts, 12-bit code
    // ********************************************
    localparam int VB_W = 12;
    localparam logic [11:0] CHOP_ON_230 = 12'h190;   // 400 V
    localparam logic [11:0] CHOP_OFF_230 = 12'h17c;  // 380 V
    localparam logic [11:0] CHOP_ON_400 = 12'h2d0;   // 720 V
    localparam logic [11:0] CHOP_OFF_400 = 12'h2a8;  // 680 V
    // ********************************************
    // timing
    // ********************************************
    localparam int CLK_MHZ = 125;
    localparam int CHECK_PERIOD_US = 2000;
    localparam int CHECK_CYCLES = CHECK_PERIOD_US * CLK_MHZ;
    localparam int STOP_TIMEOUT_MS = 5000;
    localparam int STOP_TIMEOUT_CYCLES = STOP_TIMEOUT_MS * 1000 * CLK_MHZ;
    // ********************************************
    // reset values of settings and error codes
    // ********************************************
    localparam logic ENABLE_LOSS_RESP_RST = 1'b0;
    localparam logic FAULT_ACTION_RST = 1'b1;
    localparam logic [3:0] ERR_NONE = 4'h0;
    localparam logic [3:0] ERR_OVERVOLT = 4'h1;
    localparam logic [3:0] ERR_INPUT_PHASE = 4'h2;
    localparam logic [3:0] ERR_UNDERVOLT = 4'h3;
    typedef enum logic [2:0] {BBFS_OFF, BBFS_RUN, BBFS_RAMP, BBFS_COAST} bbfs_state_e;
endpackage

// *** sim/bbfs_controller.sv ***
// partner model: machine controller on enable, stop pins and ready contact
`timescale 1ns/1ns
module bbfs_controller (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // commands from the bench
    input wire logic run_req,
    input wire logic cat0_req,
    input wire logic cat1_req,
    input wire logic stop_cat_mode,
    // device side
    input wire logic ready_to_operate_contact,
    output logic enable_pin,
    output logic stop_cat0_pin,
    output logic stop_cat1_pin,
    output logic enable_loss_response,
    output logic fault_action_select,
    output logic fault_seen_q
);
    // both settings move together; mixed values are no documented stop mode
    assign enable_loss_response = stop_cat_mode;
    assign fault_action_select = stop_cat_mode;
    // bench already drives off the sampling edge, so pins pass straight through
    assign enable_pin = run_req;
    assign stop_cat0_pin = cat0_req;
    assign stop_cat1_pin = cat1_req;
    // an opened contact is remembered until reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fault_seen_q <= 1'b0;
        end else if (!ready_to_operate_contact) begin
            fault_seen_q <= 1'b1;
        end
    end
endmodule // bbfs_controller

// *** sim/bbfs_ctrl_test.sv ***
// self-checking bench for the bus brake and fault stop controller
`timescale 1ns/1ns
module bbfs_ctrl_test;
    // ********************************************
    // signals
    // ********************************************
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic supply_class_400 = 1'b0;
    logic phase_loss_response = 1'b0;
    logic holding_brake_enable = 1'b0;
    logic [11:0] bus_voltage = 12'h140;
    logic brake_power_over = 1'b0;
    logic phase_missing_pin = 1'b0;
    logic standstill = 1'b0;
    logic fault_clear = 1'b0;
    logic run_req = 1'b0;
    logic cat0_req = 1'b0;
    logic cat1_req = 1'b0;
    logic stop_cat_mode = 1'b1;
    logic [11:0] bus_voltage_minimum = 12'h0c8;
    // short bus check period keeps overvoltage and undervoltage tests brief
    localparam int CHK_P = 40;
    logic enable_pin, stop_cat0_pin, stop_cat1_pin, enable_loss_response, fault_action_select, fault_seen_q;
    logic chopper_on, brake_power_exceeded, power_stage_on, ramp_active, special_off_seq, current_limit;
    logic ready_to_operate_contact, phase_missing_warning, mains_not_ready_error;
    logic [3:0] error_code_query;
    logic [2:0] stop_status;
    logic [11:0] on_t [2] = '{12'h190, 12'h2d0};
    logic [11:0] off_t [2] = '{12'h17c, 12'h2a8};
    int err_total = 0;
    int comparisons = 0;

    bbfs_controller ctl (.clk_sys(clk_sys), .rst(rst), .run_req(run_req), .cat0_req(cat0_req),
        .cat1_req(cat1_req), .stop_cat_mode(stop_cat_mode), .ready_to_operate_contact(ready_to_operate_contact),
        .enable_pin(enable_pin), .stop_cat0_pin(stop_cat0_pin), .stop_cat1_pin(stop_cat1_pin),
        .enable_loss_response(enable_loss_response), .fault_action_select(fault_action_select),
        .fault_seen_q(fault_seen_q));
    bbfs_ctrl #(.CHECK_CYCLES_P(CHK_P)) DUT (.clk_sys(clk_sys), .rst(rst), .supply_class_400(supply_class_400),
        .enable_loss_response(enable_loss_response), .fault_action_select(fault_action_select),
        .phase_loss_response(phase_loss_response), .holding_brake_enable(holding_brake_enable),
        .bus_voltage_minimum(bus_voltage_minimum), .bus_voltage(bus_voltage), .brake_power_over(brake_power_over),
        .phase_missing_pin(phase_missing_pin), .enable_pin(enable_pin), .stop_cat0_pin(stop_cat0_pin),
        .stop_cat1_pin(stop_cat1_pin), .standstill(standstill), .fault_clear(fault_clear),
        .chopper_on(chopper_on), .brake_power_exceeded(brake_power_exceeded), .power_stage_on(power_stage_on),
        .ramp_active(ramp_active), .special_off_seq(special_off_seq), .current_limit(current_limit),
        .ready_to_operate_contact(ready_to_operate_contact), .phase_missing_warning(phase_missing_warning),
        .mains_not_ready_error(mains_not_ready_error), .error_code_query(error_code_query),
        .stop_status(stop_status));

    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    // ********************************************
    // tasks
    // ********************************************
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_val(input logic [3:0] got, input logic [3:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chop(input logic cls, input logic [11:0] v, input logic exp);
        supply_class_400 = cls;
        bus_voltage = v;
        cyc(2);
        chk_bit(chopper_on, exp);
    endtask
    task automatic go_run;
        run_req = 1'b1;
        cyc(6);
        chk_val({1'b0, stop_status}, 4'h1);
        chk_bit(power_stage_on, 1'b1);
    endtask
    // standstill must pass the synchroniser before the ramp may end
    task automatic end_ramp;
        standstill = 1'b1;
        run_req = 1'b0;
        cyc(6);
        chk_val({1'b0, stop_status}, 4'h0);
        chk_bit(power_stage_on, 1'b0);
        standstill = 1'b0;
        cyc(4);
    endtask
    task automatic clr;
        fault_clear = 1'b1;
        cyc(1);
        fault_clear = 1'b0;
        cyc(3);
    endtask
    task automatic summarize;
        if (err_total == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ********************************************
    // tests
    // ********************************************
    initial begin
        cyc(20);
        chk_bit(ready_to_operate_contact, 1'b1);
        chk_val({1'b0, stop_status}, 4'h0);
        rst = 1'b0;
        cyc(3);
        for (int c = 0; c < 2; c++) begin
            chop(c[0], on_t[c] - 12'h001, 1'b0);
            chop(c[0], on_t[c], 1'b1);
            chop(c[0], off_t[c] + 12'h001, 1'b1);
            chop(c[0], off_t[c], 1'b0);
        end
        chop(1'b1, 12'h2d0, 1'b1);
        brake_power_over = 1'b1;
        cyc(2);
        brake_power_over = 1'b0;
        cyc(2);
        chk_bit(brake_power_exceeded, 1'b1);
        chk_bit(chopper_on, 1'b0);
        bus_voltage = 12'h140;
        clr();
        chk_bit(brake_power_exceeded, 1'b0);
        stop_cat_mode = 1'b0;
        go_run();
        run_req = 1'b0;
        cyc(6);
        chk_bit(power_stage_on, 1'b0);
        chk_bit(ramp_active, 1'b0);
        holding_brake_enable = 1'b1;
        go_run();
        run_req = 1'b0;
        cyc(6);
        chk_bit(ramp_active, 1'b1);
        chk_bit(special_off_seq, 1'b1);
        end_ramp();
        holding_brake_enable = 1'b0;
        stop_cat_mode = 1'b1;
        go_run();
        run_req = 1'b0;
        cyc(6);
        chk_bit(ramp_active, 1'b1);
        chk_bit(power_stage_on, 1'b1);
        end_ramp();
        go_run();
        cat1_req = 1'b1;
        cyc(6);
        chk_val({1'b0, stop_status}, 4'h2);
        end_ramp();
        cat1_req = 1'b0;
        go_run();
        cat0_req = 1'b1;
        cat1_req = 1'b1;
        cyc(12);
        chk_val({1'b0, stop_status}, 4'h3);
        chk_bit(power_stage_on, 1'b0);
        run_req = 1'b0;
        cat0_req = 1'b0;
        cat1_req = 1'b0;
        cyc(6);
        go_run();
        phase_missing_pin = 1'b1;
        cyc(6);
        chk_bit(phase_missing_warning, 1'b1);
        chk_bit(current_limit, 1'b1);
        chk_bit(mains_not_ready_error, 1'b1);
        chk_bit(power_stage_on, 1'b1);
        chk_bit(ready_to_operate_contact, 1'b1);
        phase_missing_pin = 1'b0;
        run_req = 1'b0;
        cyc(6);
        end_ramp();
        clr();
        phase_loss_response = 1'b1;
        go_run();
        phase_missing_pin = 1'b1;
        cyc(6);
        chk_val(error_code_query, 4'h2);
        chk_bit(ready_to_operate_contact, 1'b0);
        chk_bit(ramp_active, 1'b1);
        chk_bit(fault_seen_q, 1'b1);
        end_ramp();
        phase_missing_pin = 1'b0;
        cyc(4);
        clr();
        chk_bit(ready_to_operate_contact, 1'b1);
        chk_val(error_code_query, 4'h0);
        // each CHK_P + 4 wait below spans at least one periodic bus check
        supply_class_400 = 1'b0;
        bus_voltage = 12'h190;
        go_run();
        brake_power_over = 1'b1;
        cyc(1);
        brake_power_over = 1'b0;
        cyc(CHK_P + 4);
        chk_val(error_code_query, 4'h1);
        chk_bit(ready_to_operate_contact, 1'b0);
        chk_val({1'b0, stop_status}, 4'h3);
        chk_bit(power_stage_on, 1'b0);
        bus_voltage = 12'h140;
        run_req = 1'b0;
        cyc(6);
        clr();
        chk_val(error_code_query, 4'h0);
        chk_bit(brake_power_exceeded, 1'b0);
        bus_voltage_minimum = 12'h140;
        go_run();
        cyc(CHK_P + 4);
        chk_bit(ready_to_operate_contact, 1'b1);
        bus_voltage_minimum = 12'h141;
        cyc(CHK_P + 4);
        chk_val(error_code_query, 4'h3);
        chk_bit(ready_to_operate_contact, 1'b0);
        chk_bit(ramp_active, 1'b1);
        bus_voltage_minimum = 12'h0c8;
        end_ramp();
        clr();
        stop_cat_mode = 1'b0;
        go_run();
        bus_voltage_minimum = 12'h141;
        cyc(CHK_P + 4);
        chk_val({1'b0, stop_status}, 4'h3);
        chk_bit(power_stage_on, 1'b0);
        bus_voltage_minimum = 12'h0c8;
        run_req = 1'b0;
        cyc(6);
        clr();
        chk_bit(ready_to_operate_contact, 1'b1);
        summarize();
    end
    // the whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        summarize();
    end
endmodule // bbfs_ctrl_test
